// ===== pwmd_defines.vh
`ifndef PWMD_DEFINES_VH
`define PWMD_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PWMD_ADDR_DT_PRESCALE_LENGTH 8'he5
`define PWMD_ADDR_DT_EDGE_ENABLE 8'he6
`define PWMD_ADDR_OUT_MODE_BRAKE 8'he7
`define PWMD_ADDR_IRQ_STATUS 8'hf0
`define PWMD_ADDR_IRQ_CLEAR 8'hf1
`define PWMD_ADDR_IRQ_ENABLE 8'hf2

// ****************************************************************
// Field positions
// ****************************************************************
`define PWMD_PRESCALE_MSB 7
`define PWMD_PRESCALE_LSB 6
`define PWMD_LENGTH_MSB 5
`define PWMD_LENGTH_LSB 0
`define PWMD_EDGE_MSB 7
`define PWMD_EDGE_LSB 4
`define PWMD_DT_EN_MSB 3
`define PWMD_DT_EN_LSB 0
`define PWMD_OM_MSB 7
`define PWMD_OM_LSB 4
`define PWMD_BRAKE_BIT 0
`define PWMD_IRQ_BRAKE_ON 0
`define PWMD_IRQ_BRAKE_OFF 1

// ****************************************************************
// Reset values
// ****************************************************************
`define PWMD_RST_PRESCALE_LENGTH 8'h00
`define PWMD_RST_EDGE_ENABLE 8'h00
`define PWMD_RST_OUT_MODE 4'h0
`define PWMD_RST_IRQ 2'h0

// ****************************************************************
// Dead-time clock divider terminal counts (divisor minus one)
// ****************************************************************
`define PWMD_DIV2_LAST 4'h1
`define PWMD_DIV4_LAST 4'h3
`define PWMD_DIV8_LAST 4'h7
`define PWMD_DIV16_LAST 4'hf

`endif

// ===== pwmd_deadtime_pair.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One complementary channel pair with dead-time insertion
// ****************************************************************
module pwmd_deadtime_pair (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Dead-time clock enable and settings
    input wire dt_tick,
    input wire [5:0] dt_length,
    input wire dt_enable,
    input wire edge_fall,
    input wire compl_mode,
    // Comparator waveforms of the pair
    input wire wave_even,
    input wire wave_odd,
    // Pair outputs
    output reg out_even,
    output reg out_odd
);

    reg wave_q;
    reg [6:0] dt_count;
    wire dt_active;
    wire dt_done;
    reg next_even;
    reg next_odd;

    // Insertion only counts in complementary mode
    assign dt_active = dt_enable & compl_mode;
    // Zero length means no delay; otherwise wait for length+1 ticks, since
    // the first tick after an edge may close only a partial period. The count
    // left over from the previous edge must not count in the edge cycle.
    assign dt_done = (dt_length == 6'h00) ||
                     ((wave_even == wave_q) && (dt_count > {1'b0, dt_length}));

    // Dead-time counter restarts at every edge of the source waveform
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wave_q <= 1'b0;
            dt_count <= 7'h00;
        end else begin
            wave_q <= wave_even;
            if (wave_even != wave_q) begin
                dt_count <= 7'h00;
            end else if (dt_tick && !dt_done) begin
                dt_count <= dt_count + 7'h01;
            end
        end
    end

    // Output selection: independent, plain complement or delayed rise
    always @* begin
        next_even = wave_even;
        next_odd = wave_odd;
        if (compl_mode) begin
            next_even = wave_even;
            next_odd = ~wave_even;
            if (dt_active) begin
                // Only a low-to-high transition waits, so both never overlap
                next_even = wave_even & (edge_fall | dt_done);
                next_odd = ~wave_even & (~edge_fall | dt_done);
            end
        end
    end

    // Registered outputs keep glitches off the power stage
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_even <= 1'b0;
            out_odd <= 1'b0;
        end else begin
            out_even <= next_even;
            out_odd <= next_odd;
        end
    end

endmodule // pwmd_deadtime_pair

`default_nettype wire

// ===== pwmd_output_stage.v
`timescale 1ns/1ps
`default_nettype none
`include "pwmd_defines.vh"

module pwmd_output_stage (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // PWM core waveforms and pair modes
    input wire [7:0] pwm_wave,
    input wire [3:0] pair_compl,
    // Option bits, active low enable
    input wire even_channel_option,
    input wire odd_channel_option,
    // Port latches and program source
    input wire [7:0] port_latch,
    input wire ext_exec,
    input wire [7:0] ext_access_out,
    // External brake pin, active high
    input wire brake_in,
    // Output pins toward the power stage
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe,
    output reg [7:0] pin_weak_pullup,
    output reg [7:0] pin_strong,
    // Interrupt
    output wire irq
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg [7:0] deadtime_prescale_length;
    reg [7:0] deadtime_edge_enable;
    reg [3:0] out_mode;
    reg brake_flag;
    reg [1:0] irq_status;
    reg [1:0] irq_enable;
    reg brake_q;

    wire wr_prescale;
    wire wr_edge;
    wire wr_mode;
    wire wr_clear;
    wire wr_enable;
    wire brake_rise;
    wire brake_fall;
    wire [1:0] irq_event;
    wire [1:0] irq_clr;

    assign wr_prescale = reg_wr && (reg_addr == `PWMD_ADDR_DT_PRESCALE_LENGTH);
    assign wr_edge = reg_wr && (reg_addr == `PWMD_ADDR_DT_EDGE_ENABLE);
    assign wr_mode = reg_wr && (reg_addr == `PWMD_ADDR_OUT_MODE_BRAKE);
    assign wr_clear = reg_wr && (reg_addr == `PWMD_ADDR_IRQ_CLEAR);
    assign wr_enable = reg_wr && (reg_addr == `PWMD_ADDR_IRQ_ENABLE);

    // Brake edges feed the interrupt status; the flag is set by the pin level
    assign brake_rise = brake_in & ~brake_q;
    assign brake_fall = ~brake_in & brake_q;
    assign irq_event = {brake_fall, brake_rise};
    assign irq_clr = wr_clear ? reg_wdata[1:0] : 2'h0;

    // Configuration registers
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            deadtime_prescale_length <= `PWMD_RST_PRESCALE_LENGTH;
            deadtime_edge_enable <= `PWMD_RST_EDGE_ENABLE;
            out_mode <= `PWMD_RST_OUT_MODE;
        end else begin
            if (wr_prescale) begin
                deadtime_prescale_length <= reg_wdata;
            end
            if (wr_edge) begin
                deadtime_edge_enable <= reg_wdata;
            end
            if (wr_mode) begin
                out_mode <= reg_wdata[`PWMD_OM_MSB:`PWMD_OM_LSB];
            end
        end
    end

    // Brake flag: level of the pin keeps it set, software writes zero
    // to clear; a brake still present wins over the clear
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            brake_q <= 1'b0;
            brake_flag <= 1'b0;
        end else begin
            brake_q <= brake_in;
            if (brake_in) begin
                brake_flag <= 1'b1;
            end else if (wr_mode && !reg_wdata[`PWMD_BRAKE_BIT]) begin
                brake_flag <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, set wins over clear
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= `PWMD_RST_IRQ;
            irq_enable <= `PWMD_RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_event;
            if (wr_enable) begin
                irq_enable <= reg_wdata[1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_enable);

    // Read data one cycle after the strobe, zero elsewhere.
    // Zero outside the read slot lets several slaves share one
    // read bus by a plain OR, at the cost of one register stage.
    // The clear register at 0xf1 is write-only and reads as zero.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PWMD_ADDR_DT_PRESCALE_LENGTH: begin
                    reg_rdata <= deadtime_prescale_length;
                end
                `PWMD_ADDR_DT_EDGE_ENABLE: begin
                    reg_rdata <= deadtime_edge_enable;
                end
                `PWMD_ADDR_OUT_MODE_BRAKE: begin
                    reg_rdata <= {out_mode, 3'h0, brake_flag};
                end
                `PWMD_ADDR_IRQ_STATUS: begin
                    reg_rdata <= {6'h00, irq_status};
                end
                `PWMD_ADDR_IRQ_ENABLE: begin
                    reg_rdata <= {6'h00, irq_enable};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // Dead-time clock prescaler
    // ****************************************************************
    reg [3:0] prescale_count;
    reg [3:0] prescale_last;
    reg dt_tick;

    // Divisor from the two prescale bits.
    // The prescaler runs free, so the phase of the first tick after a
    // waveform edge is arbitrary; the pair logic counts one extra tick.
    always @* begin
        case (deadtime_prescale_length[`PWMD_PRESCALE_MSB:`PWMD_PRESCALE_LSB])
            2'h0: prescale_last = `PWMD_DIV2_LAST;
            2'h1: prescale_last = `PWMD_DIV4_LAST;
            2'h2: prescale_last = `PWMD_DIV8_LAST;
            default: prescale_last = `PWMD_DIV16_LAST;
        endcase
    end

    // One-cycle enable per dead-time clock period; a shorter divisor
    // taking effect mid-count simply wraps at the next terminal match
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prescale_count <= 4'h0;
            dt_tick <= 1'b0;
        end else begin
            if (prescale_count >= prescale_last) begin
                prescale_count <= 4'h0;
                dt_tick <= 1'b1;
            end else begin
                prescale_count <= prescale_count + 4'h1;
                dt_tick <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Channel pairs
    // ****************************************************************
    wire [7:0] wave_run;
    wire [7:0] pair_out;
    wire [5:0] dt_length;

    // Brake holds every waveform low until software releases the flag
    assign wave_run = brake_flag ? 8'h00 : pwm_wave;
    assign dt_length = deadtime_prescale_length[`PWMD_LENGTH_MSB:`PWMD_LENGTH_LSB];

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_pair
            pwmd_deadtime_pair u_pair (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .dt_tick(dt_tick),
                .dt_length(dt_length),
                .dt_enable(deadtime_edge_enable[`PWMD_DT_EN_LSB + p]),
                .edge_fall(deadtime_edge_enable[`PWMD_EDGE_LSB + p]),
                .compl_mode(pair_compl[p]),
                .wave_even(wave_run[2 * p]),
                .wave_odd(wave_run[2 * p + 1]),
                .out_even(pair_out[2 * p]),
                .out_odd(pair_out[2 * p + 1])
            );
        end
    endgenerate

    // ****************************************************************
    // Pin structure
    // ****************************************************************
    wire [7:0] pin_mode;
    wire [7:0] pin_option_off;
    reg [7:0] next_out;
    reg [7:0] next_oe;
    reg [7:0] next_pullup;
    reg [7:0] next_strong;
    integer i;

    // Group mapping of output-mode bits onto channels
    assign pin_mode = {out_mode[0], out_mode[1], out_mode[2], out_mode[3],
                       out_mode[2], out_mode[3], out_mode[2], out_mode[3]};
    assign pin_option_off = {odd_channel_option, even_channel_option,
                             odd_channel_option, even_channel_option,
                             odd_channel_option, even_channel_option,
                             odd_channel_option, even_channel_option};

    // Per-pin driver selection.
    // External program execution overrides everything, since the pins
    // then carry the memory bus. Quasi mode only drives low; the high
    // level comes from the weak pull-up, so a shared line can still be
    // pulled low from outside. Push-pull drives both levels.
    always @* begin
        next_out = 8'h00;
        next_oe = 8'h00;
        next_pullup = 8'h00;
        next_strong = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            if (ext_exec) begin
                // External memory access owns the pins outright
                next_out[i] = ext_access_out[i];
                next_oe[i] = 1'b1;
                next_strong[i] = ~pin_option_off[i];
            end else if (!pin_mode[i]) begin
                next_oe[i] = 1'b0;
            end else if (pin_option_off[i]) begin
                // Quasi: drives low hard, pulls high weakly
                next_out[i] = port_latch[i];
                next_oe[i] = ~port_latch[i];
                next_pullup[i] = 1'b1;
            end else begin
                next_out[i] = port_latch[i] ? 1'b1 : pair_out[i];
                next_oe[i] = 1'b1;
            end
        end
    end

    // Registered pin drivers, all released during reset.
    // A register stage here keeps decode glitches off the power stage.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            pin_weak_pullup <= 8'h00;
            pin_strong <= 8'h00;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            pin_weak_pullup <= next_pullup;
            pin_strong <= next_strong;
        end
    end

endmodule // pwmd_output_stage

`default_nettype wire

// ===== pwmd_output_stage_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module pwmd_output_stage_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pin controls
    input wire logic even_channel_option,
    input wire logic odd_channel_option,
    input wire logic [7:0] port_latch,
    input wire logic ext_exec,
    input wire logic [7:0] ext_access_out,
    input wire logic brake_in,
    // Pins and interrupt
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_weak_pullup,
    input wire logic [7:0] pin_strong,
    input wire logic irq
);
    logic [3:0] mode;
    logic [1:0] irq_en;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Shadow of mode bits and irq enable, written like the real ones
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode <= 4'h0;
            irq_en <= 2'h0;
        end else if (reg_wr && reg_addr == 8'he7) begin
            mode <= reg_wdata[7:4];
        end else if (reg_wr && reg_addr == 8'hf2) begin
            irq_en <= reg_wdata[1:0];
        end
    end
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_read: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mode_readback: assert property (reg_rd && reg_addr == 8'he7 |=>
        reg_rdata[7:4] == $past(mode) && reg_rdata[3:1] == 3'h0)
        else $error("mode bits read wrong");
    a_tristate_off: assert property ($past(arst_n && !ext_exec && !mode[3]) |-> !pin_oe[0])
        else $error("pin driven with mode bit clear");
    a_quasi_pin: assert property ($past(arst_n && !ext_exec && mode[3] && even_channel_option)
        |-> pin_weak_pullup[0] && pin_oe[0] == !$past(port_latch[0]))
        else $error("quasi structure wrong");
    a_push_io: assert property ($past(arst_n && !ext_exec && mode[3] && !even_channel_option
        && port_latch[0]) |-> pin_oe[0] && pin_out[0] && !pin_weak_pullup[0])
        else $error("push-pull io wrong");
    a_ext_access: assert property ($past(arst_n && ext_exec)
        |-> pin_oe == 8'hff && pin_out == $past(ext_access_out))
        else $error("external access not driven");
    a_ext_strong: assert property ($past(arst_n && ext_exec) |->
        pin_strong[0] == !$past(even_channel_option) && pin_strong[1] == !$past(odd_channel_option))
        else $error("strong drive wrong");
    a_brake_flag: assert property (reg_rd && reg_addr == 8'he7 && $past(brake_in) |=> reg_rdata[0])
        else $error("brake flag not set");
    a_irq_masked: assert property (irq_en == 2'h0 |-> !irq)
        else $error("irq while disabled");
    c_ext: cover property (pin_oe == 8'hff && pin_strong != 8'h00);
    c_irq: cover property (irq);
    c_quasi: cover property (pin_weak_pullup[0] && !pin_oe[0]);
endmodule // pwmd_output_stage_monitor
bind pwmd_output_stage pwmd_output_stage_monitor pwmd_output_stage_monitor_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .even_channel_option(even_channel_option), .odd_channel_option(odd_channel_option),
    .port_latch(port_latch), .ext_exec(ext_exec), .ext_access_out(ext_access_out),
    .brake_in(brake_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_weak_pullup(pin_weak_pullup), .pin_strong(pin_strong), .irq(irq));
`default_nettype wire

// ===== pwmd_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Power stage model behind the pins
// ****************************************************************
module pwmd_power_stage (
    // Clock
    input wire logic clk_sys,
    // Pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_weak_pullup,
    // Fault trip
    input wire logic trip,
    // Wire level and brake line
    output logic [7:0] pin_level,
    output logic brake_in
);
    logic [7:0] last;
    // Undriven pins float away from the last level unless pulled up
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & (pin_weak_pullup | ~last));
    initial last = 8'h00;
    initial brake_in = 1'b0;
    // Brake line follows a fault one clock later
    always @(posedge clk_sys) begin
        last <= pin_level;
        brake_in <= trip;
    end
endmodule // pwmd_power_stage
`default_nettype wire

// ===== pwmd_output_stage_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench
// ****************************************************************
module pwmd_output_stage_test;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pwm_wave = 8'h00;
    logic [7:0] port_latch = 8'h00, ext_access_out = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ext_exec = 1'b0, trip = 1'b0;
    logic even_channel_option = 1'b0, odd_channel_option = 1'b0;
    logic [3:0] pair_compl = 4'h0;
    logic [7:0] oe_tab [4] = '{8'h15, 8'h2a, 8'h40, 8'h80};
    wire logic [7:0] reg_rdata, pin_out, pin_oe, pin_weak_pullup, pin_strong, pin_level;
    wire logic irq, brake_in;
    int bad_count = 0, n_compared = 0, cycles = 0;
    always #2 clk_sys = ~clk_sys;
    pwmd_output_stage pwmd_output_stage_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_wave(pwm_wave), .pair_compl(pair_compl),
        .even_channel_option(even_channel_option), .odd_channel_option(odd_channel_option),
        .port_latch(port_latch), .ext_exec(ext_exec), .ext_access_out(ext_access_out),
        .brake_in(brake_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_weak_pullup(pin_weak_pullup), .pin_strong(pin_strong), .irq(irq));
    pwmd_power_stage pwmd_power_stage_inst (.clk_sys(clk_sys), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_weak_pullup(pin_weak_pullup), .trip(trip),
        .pin_level(pin_level), .brake_in(brake_in));
    // Verdict and end of run
    task stop_test;
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Let the edge's updates land before looking
    task look(input int n);
        tick(n);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task s_pins;
        wr(8'he7, 8'h00);
        port_latch <= 8'hff;
        look(3);
        chk(pin_oe, 8'h00);
        wr(8'he7, 8'hf0);
        {even_channel_option, odd_channel_option, port_latch} <= {2'b11, 8'h0f};
        look(3);
        chk(pin_oe, 8'hf0);
        chk(pin_level, 8'h0f);
        tick(1);
        {even_channel_option, odd_channel_option, port_latch} <= {2'b00, 8'hff};
        look(3);
        chk(pin_out & pin_oe & ~pin_weak_pullup, 8'hff);
        tick(1);
        port_latch <= 8'h00;
        for (int i = 0; i < 4; i++) begin
            wr(8'he7, 8'h80 >> i);
            look(3);
            chk(pin_oe, oe_tab[i]);
        end
        {ext_exec, ext_access_out, odd_channel_option} <= {1'b1, 8'ha5, 1'b1};
        look(3);
        chk(pin_out & pin_oe, 8'ha5);
        chk(pin_strong, 8'h55);
        tick(1);
        {ext_exec, odd_channel_option} <= 2'b00;
    endtask
    task s_compl;
        wr(8'he7, 8'hf0);
        wr(8'he6, 8'h00);
        {pair_compl, pwm_wave} <= {4'h1, 8'h01};
        look(4);
        chk(pin_out & 8'h03, 8'h01);
        pwm_wave <= 8'h00;
        look(4);
        chk(pin_out & 8'h03, 8'h02);
        wr(8'he6, 8'h01);
        {pair_compl, pwm_wave} <= {4'h0, 8'h02};
        look(4);
        chk(pin_out & 8'h03, 8'h02);
    endtask
    // Delayed edge must land within length..length+1 dead-time periods
    task s_dt(input logic [1:0] pre, input logic fall);
        int n;
        int dv;
        dv = 2 << pre;
        wr(8'he5, {pre, 6'h05});
        wr(8'he6, {3'h0, fall, 4'h1});
        {pair_compl, pwm_wave} <= {4'h1, 7'h00, fall};
        tick(20);
        pwm_wave <= {7'h00, !fall};
        look(3);
        chk(pin_out & 8'h03, 8'h00);
        n = 3;
        while (pin_out[fall] !== 1'b1 && n < 300) begin
            look(1);
            n++;
        end
        chk(8'(n >= 5 * dv && n <= 6 * dv + 4), 8'h01);
        chk(pin_out & 8'h03, fall ? 8'h02 : 8'h01);
    endtask
    task s_brake;
        wr(8'hf2, 8'h01);
        trip <= 1'b1;
        tick(2);
        rd(8'he7, 8'hf1);
        trip <= 1'b0;
        look(3);
        chk({7'h00, irq}, 8'h01);
        rd(8'hf0, 8'h03);
        wr(8'hf1, 8'h01);
        look(1);
        chk({7'h00, irq}, 8'h00);
        rd(8'he7, 8'hf1);
        wr(8'he7, 8'hf0);
        rd(8'he7, 8'hf0);
        wr(8'hf2, 8'h00);
        trip <= 1'b1;
        tick(3);
        trip <= 1'b0;
        look(3);
        chk({7'h00, irq}, 8'h00);
        rd(8'hf0, 8'h03);
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        tick(4);
        #1 chk(pin_oe, 8'h00);
        tick(4);
        arst_n <= 1'b1;
        rd(8'he5, 8'h00);
        rd(8'he6, 8'h00);
        rd(8'he7, 8'h00);
        wr(8'he6, 8'ha5);
        rd(8'he6, 8'ha5);
        wr(8'he7, 8'hff);
        rd(8'he7, 8'hf0);
        rd(8'h10, 8'h00);
        rd(8'hf1, 8'h00);
        s_pins();
        s_compl();
        for (int p = 0; p < 4; p++) s_dt(2'(p), 1'b0);
        s_dt(2'h1, 1'b1);
        s_brake();
        stop_test();
    end
endmodule // pwmd_output_stage_test
`default_nettype wire
